// [four_channel_bridge_pwm_unit.sv]
// Operation
// - own 3-bit chopper mode per channel
// - one alignment setting for all channels
// - one polarity bit for all low sides
// - one polarity bit for all high sides
// - own polarity bit per trigger output
// - low side dead time in 100MHz cycles
// - high side dead time in 100MHz cycles
// - per channel 12-bit on-time sets duty
// - per channel shift offsets edges
// - pulses A and B at programmed positions
// - one common length for trigger pulses
module four_channel_bridge_pwm_unit
#(
   parameter int NCH = 4   // number of bridge channels
)(
   input  wire logic                      ref_clk_i,
   input  wire logic                      arst_n_i,
   input  wire logic                      fieldbus_wr_i,
   input  wire logic [pwm_unit_pkg::IDX_W-1:0] fieldbus_idx_i,
   input  wire logic [pwm_unit_pkg::CFG_W-1:0] fieldbus_wdata_i,
   input  wire logic                      local_host_data_port_wr_i,
   input  wire logic [pwm_unit_pkg::IDX_W-1:0] local_host_data_port_idx_i,
   input  wire logic [pwm_unit_pkg::CFG_W-1:0] local_host_data_port_wdata_i,
   output logic [NCH-1:0]                 pwm_hs_o,
   output logic [NCH-1:0]                 pwm_ls_o,
   output logic                           trig_ab_o,
   output logic                           trig_b_o,
   output logic                           trig_center_o,
   output logic                           trig_a_o,
   output logic                           trig_zero_o
);
   import pwm_unit_pkg::*;

   // ----------------------------------------------------------------
   // write port merge
   // ----------------------------------------------------------------
   logic             wr_en;    // any write this cycle
   logic [IDX_W-1:0] wr_idx;   // selected register index
   logic [CFG_W-1:0] wr_data;  // selected write data

   // fieldbus wins a same-cycle collision; the local write is lost
   assign wr_en   = fieldbus_wr_i | local_host_data_port_wr_i;
   assign wr_idx  = fieldbus_wr_i ? fieldbus_idx_i
                                  : local_host_data_port_idx_i;
   assign wr_data = fieldbus_wr_i ? fieldbus_wdata_i
                                  : local_host_data_port_wdata_i;

   // ----------------------------------------------------------------
   // write-only registers
   // ----------------------------------------------------------------
   logic [CFG_W-1:0]  cfg_reg;           // configuration word
   logic [CNT_W-1:0]  duty_reg  [NCH];   // on-time per channel
   logic [CNT_W-1:0]  shift_reg [NCH];   // counter shift per channel
   logic [CNT_W-1:0]  pos_a_reg;         // trigger A position
   logic [CNT_W-1:0]  pos_b_reg;         // trigger B position
   logic [PLEN_W-1:0] plen_reg;          // trigger pulse length

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cfg_reg   <= CFG_RST;
         pos_a_reg <= CNT_RST;
         pos_b_reg <= CNT_RST;
         plen_reg  <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            duty_reg[i]  <= CNT_RST;
            shift_reg[i] <= CNT_RST;
         end
      end
      else if (wr_en)
      begin
         if (wr_idx == IDX_CFG)
            cfg_reg <= wr_data;
         if (wr_idx == IDX_PULSE_AB)
         begin
            pos_a_reg <= wr_data[POS_A_LSB +: CNT_W];
            pos_b_reg <= wr_data[POS_B_LSB +: CNT_W];
         end
         if (wr_idx == IDX_PULSE_LEN)
            plen_reg <= wr_data[PLEN_W-1:0];
         // upper unused bits of narrow registers are dropped
         for (int i = 0; i < NCH; i++)
         begin
            if (wr_idx == IDX_DUTY0 + IDX_W'(i))
               duty_reg[i] <= wr_data[CNT_W-1:0];
            if (wr_idx == IDX_SHIFT0 + IDX_W'(i))
               shift_reg[i] <= wr_data[CNT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] max_w;      // period end value
   align_e           align_w;    // common alignment
   logic [DTC_W-1:0] dt_ls_w;    // low side dead time, own cycles
   logic [DTC_W-1:0] dt_hs_w;    // high side dead time, own cycles
   logic [CNT_W-1:0] half_w;     // middle of the period

   // dead time is given in 10 ns units; round up to 8 ns cycles so
   // the gap is never shorter than programmed
   function automatic logic [DTC_W-1:0] dt_cycles(
      input logic [DT_W-1:0] n);
      logic [15:0] ns;
      ns = 16'(n) * 16'(DT_UNIT_NS);
      return DTC_W'((ns + 16'(CLK_PERIOD_NS - 1)) / 16'(CLK_PERIOD_NS));
   endfunction

   assign max_w   = cfg_reg[CFG_MAX_LSB +: CNT_W];
   assign align_w = align_e'(cfg_reg[CFG_ALN_LSB +: ALN_W]);
   assign dt_ls_w = dt_cycles(cfg_reg[CFG_BBM_LS +: DT_W]);
   assign dt_hs_w = dt_cycles(cfg_reg[CFG_BBM_HS +: DT_W]);
   assign half_w  = max_w >> 1;

   // ----------------------------------------------------------------
   // shared period counter
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_reg;

   // >= rather than == so a lowered maximum still wraps at once
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cnt_reg <= CNT_RST;
      else if (cnt_reg >= max_w)
         cnt_reg <= CNT_RST;
      else
         cnt_reg <= cnt_reg + CNT_W'(1);
   end

   // level of one channel for its aligned count
   function automatic logic pwm_level(
      input logic [CNT_W-1:0] pos,
      input logic [CNT_W-1:0] duty,
      input logic [CNT_W-1:0] top,
      input align_e           aln);
      logic [CNT_W-1:0] tri_v;
      tri_v = (pos <= (top >> 1)) ? pos : top - pos;
      case (aln)
         ALIGN_LEFT:  return pos < duty;
         ALIGN_RIGHT: return ({1'b0, pos} + {1'b0, duty}) > {1'b0, top};
         default:     return ({1'b0, tri_v} + {1'b0, duty >> 1})
                             > {1'b0, top >> 1};
      endcase
   endfunction

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] aligned_w [NCH];  // shifted count per channel
   logic [NCH-1:0]   lvl_w;            // modulated level
   logic [NCH-1:0]   hs_req_w;         // high side request
   logic [NCH-1:0]   ls_req_w;         // low side request
   logic [NCH-1:0]   hs_dt_w;          // high side after dead time
   logic [NCH-1:0]   ls_dt_w;          // low side after dead time
   logic [NCH-1:0]   hs_out_reg;
   logic [NCH-1:0]   ls_out_reg;

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      logic [CNT_W:0] sum_w;   // count plus shift, one bit wider
      chop_mode_e     mode_w;  // this channel's chopper mode

      // one subtraction only: a shift above the period is taken once
      assign sum_w = {1'b0, cnt_reg} + {1'b0, shift_reg[c]};
      assign aligned_w[c] = (sum_w > {1'b0, max_w})
                            ? CNT_W'(sum_w - {1'b0, max_w} - 13'h001)
                            : sum_w[CNT_W-1:0];
      assign lvl_w[c] = pwm_level(aligned_w[c], duty_reg[c],
                                  max_w, align_w);
      assign mode_w = chop_mode_e'(cfg_reg[CFG_CHOP_LSB
                      + CFG_CHOP_STEP*c +: CHOP_W]);
      assign hs_req_w[c] = lvl_w[c] & ((mode_w == CHOP_COMPL)
                           | (mode_w == CHOP_HS_ONLY));
      assign ls_req_w[c] = ((mode_w == CHOP_COMPL) & ~lvl_w[c])
                           | ((mode_w == CHOP_LS_ONLY) & lvl_w[c])
                           | (mode_w == CHOP_LS_BRAKE);

      pwm_deadtime #(
         .DW         (DTC_W)
      ) pwm_deadtime_inst (
         .ref_clk_i  (ref_clk_i),
         .arst_n_i   (arst_n_i),
         .hs_req_i   (hs_req_w[c]),
         .ls_req_i   (ls_req_w[c]),
         .hs_delay_i (dt_hs_w),
         .ls_delay_i (dt_ls_w),
         .hs_o       (hs_dt_w[c]),
         .ls_o       (ls_dt_w[c])
      );
   end

   // polarity applied last so dead time is measured on real levels
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hs_out_reg <= '0;
         ls_out_reg <= '0;
      end
      else
      begin
         hs_out_reg <= hs_dt_w ^ {NCH{cfg_reg[CFG_POL_HS]}};
         ls_out_reg <= ls_dt_w ^ {NCH{cfg_reg[CFG_POL_LS]}};
      end
   end

   assign pwm_hs_o = hs_out_reg;
   assign pwm_ls_o = ls_out_reg;

   // ----------------------------------------------------------------
   // trigger pulses: zero, center, A, B
   // ----------------------------------------------------------------
   logic [3:0]        ev_w;               // zero, center, a, b events
   logic [PLEN_W-1:0] left_reg [4];       // remaining pulse cycles
   logic [PLEN_W-1:0] len_w;              // length, at least one
   logic [3:0]        act_w;              // stretched pulses
   logic [NTRIG-1:0]  trig_raw_w;
   logic [NTRIG-1:0]  trig_reg;

   assign ev_w  = {cnt_reg == pos_b_reg, cnt_reg == pos_a_reg,
                   cnt_reg == half_w, cnt_reg == CNT_RST};
   assign len_w = (plen_reg == '0) ? PLEN_W'(1) : plen_reg;

   // a new event restarts a running pulse
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int k = 0; k < 4; k++)
            left_reg[k] <= '0;
      end
      else
      begin
         for (int k = 0; k < 4; k++)
            if (ev_w[k])
               left_reg[k] <= len_w;
            else if (left_reg[k] != '0)
               left_reg[k] <= left_reg[k] - PLEN_W'(1);
      end
   end

   for (genvar k = 0; k < 4; k++)
   begin : g_act
      assign act_w[k] = left_reg[k] != '0;
   end

   assign trig_raw_w[TRIG_ZERO]   = act_w[0];
   assign trig_raw_w[TRIG_CENTER] = act_w[1];
   assign trig_raw_w[TRIG_A]      = act_w[2];
   assign trig_raw_w[TRIG_B]      = act_w[3];
   assign trig_raw_w[TRIG_AB]     = act_w[2] | act_w[3];

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         trig_reg <= '0;
      else
         trig_reg <= trig_raw_w ^ cfg_reg[CFG_POL_TRIG +: NTRIG];
   end

   assign trig_ab_o     = trig_reg[TRIG_AB];
   assign trig_b_o      = trig_reg[TRIG_B];
   assign trig_center_o = trig_reg[TRIG_CENTER];
   assign trig_a_o      = trig_reg[TRIG_A];
   assign trig_zero_o   = trig_reg[TRIG_ZERO];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_cnt_wrap; cnt_reg >= max_w |=> cnt_reg == CNT_RST; endproperty
   a_cnt_wrap: assert property (p_cnt_wrap)
      else $error("counter did not wrap at maximum");

   property p_cnt_step;
      cnt_reg < max_w |=> cnt_reg == $past(cnt_reg) + CNT_W'(1);
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("counter did not advance by one");

   property p_chop_off;
      cfg_reg[CFG_CHOP_LSB +: CHOP_W] == CHOP_OFF
      |-> !hs_req_w[0] && !ls_req_w[0];
   endproperty
   a_chop_off: assert property (p_chop_off)
      else $error("channel 0 driven in off mode");

   property p_align_right;
      align_w == ALIGN_RIGHT && aligned_w[0] == max_w && duty_reg[0] != '0
      |-> lvl_w[0];
   endproperty
   a_align_right: assert property (p_align_right)
      else $error("right aligned pulse missing at period end");

   property p_duty_zero;
      align_w == ALIGN_LEFT && duty_reg[0] == '0 |-> !lvl_w[0];
   endproperty
   a_duty_zero: assert property (p_duty_zero)
      else $error("zero on-time produced a pulse");

   property p_ls_pol;
      ##1 pwm_ls_o[0] == ($past(ls_dt_w[0]) ^ $past(cfg_reg[CFG_POL_LS]));
   endproperty
   a_ls_pol: assert property (p_ls_pol)
      else $error("low side polarity wrong");

   property p_hs_pol;
      ##1 pwm_hs_o[0] == ($past(hs_dt_w[0]) ^ $past(cfg_reg[CFG_POL_HS]));
   endproperty
   a_hs_pol: assert property (p_hs_pol)
      else $error("high side polarity wrong");

   property p_trig_a;
      cnt_reg == pos_a_reg && $stable(cfg_reg) ##1 $stable(cfg_reg)
      |=> trig_a_o != $past(cfg_reg[CFG_POL_TRIG + TRIG_A]);
   endproperty
   a_trig_a: assert property (p_trig_a)
      else $error("trigger A not asserted after its position");

   // a lowered length may leave a running pulse longer, so check the load
   property p_plen; ev_w[2] |=> left_reg[2] == $past(len_w); endproperty
   a_plen: assert property (p_plen)
      else $error("trigger pulse longer than programmed");

   property p_shift;
      shift_reg[0] == '0 && cnt_reg <= max_w |-> aligned_w[0] == cnt_reg;
   endproperty
   a_shift: assert property (p_shift)
      else $error("unshifted channel count differs from counter");

endmodule // four_channel_bridge_pwm_unit

// [four_channel_bridge_pwm_unit_bench.sv]
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
 $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module four_channel_bridge_pwm_unit_bench
   import pwm_unit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, fb_wr, lh_wr, shoot;
   logic [5:0]  fb_idx, lh_idx;    // register index per source
   logic [63:0] fb_data, lh_data;  // write data per source
   logic [3:0]  hs, ls;            // gate pins
   logic [4:0]  trig;              // ab, b, center, a, zero
   int          gap_hs, gap_ls, n_mismatch, checked;
   int          cnt [13];          // high cycles per observed pin
   wire  [12:0] obs = {trig, ls, hs};
   four_channel_bridge_pwm_unit #(.NCH(4)) four_channel_bridge_pwm_unit_inst (
      .ref_clk_i(clk), .arst_n_i(arst_n), .fieldbus_wr_i(fb_wr),
      .fieldbus_idx_i(fb_idx), .fieldbus_wdata_i(fb_data),
      .local_host_data_port_wr_i(lh_wr), .local_host_data_port_idx_i(lh_idx),
      .local_host_data_port_wdata_i(lh_data), .pwm_hs_o(hs), .pwm_ls_o(ls),
      .trig_ab_o(trig[0]), .trig_b_o(trig[1]), .trig_center_o(trig[2]),
      .trig_a_o(trig[3]), .trig_zero_o(trig[4]));
   gate_driver_model gate_driver_model_inst (.ref_clk_i(clk),
      .arst_n_i(arst_n), .hs_i(hs), .ls_i(ls), .shoot_o(shoot),
      .gap_hs_o(gap_hs), .gap_ls_o(gap_ls));
   // ------------------------------------------------------------
   // bus and measuring tasks
   // ------------------------------------------------------------
   // one-cycle write strobe from either source (1 = local port)
   task automatic wr(input logic src, input logic [5:0] i,
                     input logic [63:0] d);
      @(negedge clk);
      fb_wr   = !src;
      lh_wr   = src;
      fb_idx  = i;
      lh_idx  = i;
      fb_data = d;
      lh_data = d;
      @(negedge clk);
      fb_wr   = 1'b0;
      lh_wr   = 1'b0;
   endtask
   // settle, then count high cycles of every pin over n cycles
   task automatic meas(input int n);
      repeat (30) @(negedge clk);
      foreach (cnt[k]) cnt[k] = 0;
      repeat (n)
      begin
         @(negedge clk);
         foreach (cnt[k]) cnt[k] += int'(obs[k]);
      end
   endtask
   task automatic conclude();
      $display("counts: %0d compared, %0d wrong", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // complementary bridge 0, period 100, unequal dead times
   task automatic t_dead();
      wr(1'b0, IDX_DUTY0, 64'h32);
      wr(1'b0, IDX_CFG, 64'h1008_0000_0001_0063);
      meas(300);
      `CHK(gap_hs >= 20 && gap_hs <= 22, 1'b1)
      `CHK(gap_ls >= 10 && gap_ls <= 12, 1'b1)
      `CHK(shoot, 1'b0)
      $display("test dead time done");
   endtask
   // brake mode on bridges 1 and 3, each side polarity alone
   task automatic t_pol();
      wr(1'b1, IDX_CFG, 64'h0000_0100_4040_0000);
      meas(1);
      `CHK({hs, ls}, 8'h05)
      wr(1'b0, IDX_CFG, 64'h0000_0200_4040_0000);
      meas(1);
      `CHK({hs, ls}, 8'hfa)
      wr(1'b0, IDX_CFG, 64'h0000_0000_4040_0000);
      meas(1);
      `CHK({hs, ls}, 8'h0a)
      $display("test polarity done");
   endtask
   // period 10, high side only, left then right alignment
   task automatic t_duty();
      wr(1'b1, IDX_DUTY0, 64'h4);
      wr(1'b0, IDX_DUTY0 + 6'h1, 64'h7);
      for (int a = 0; a < 2; a++)
      begin
         wr(1'b0, IDX_CFG, {31'h0, a[0], 32'h0022_0009});
         wr(1'b0, 6'h3f, '1);  // unmapped: must change nothing
         meas(20);
         `CHK(cnt[0], 8)
         `CHK(cnt[1], 14)
         `CHK(cnt[4] + cnt[5], 0)
      end
      $display("test duty done");
   endtask
   // pulses A at 2, B at 6, length 3, then all trigger polarities
   task automatic t_trig();
      wr(1'b0, IDX_PULSE_AB, 64'h0006_0002);
      wr(1'b1, IDX_PULSE_LEN, 64'h3);
      for (int p = 0; p < 2; p++)
      begin
         wr(1'b0, IDX_CFG, p ? 64'h0000_7c00_0000_0009 : 64'h9);
         meas(20);
         `CHK(cnt[8], p ? 8 : 12)
         for (int k = 9; k < 13; k++)
            `CHK(cnt[k], p ? 14 : 6)
      end
      wr(1'b0, IDX_PULSE_LEN, 64'h5);
      meas(20);
      `CHK(cnt[11], 10)
      $display("test triggers done");
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial
   begin
      {arst_n, fb_wr, lh_wr, fb_idx, lh_idx, fb_data, lh_data} = '0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      t_dead();
      t_pol();
      t_duty();
      t_trig();
      conclude();
   end
endmodule  // four_channel_bridge_pwm_unit_bench

// [gate_driver_model.sv]
// ---------------------------------------------------------------
// gate drivers of all four half bridges, gaps timed on both gate lines of bridge 0
// ---------------------------------------------------------------
module gate_driver_model
(
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic [3:0] hs_i,
   input  wire logic [3:0] ls_i,
   output logic            shoot_o,
   output int              gap_hs_o,
   output int              gap_ls_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int   off_cnt;  // cycles with both gates of bridge 0 open
   logic hs_prev;  // last sampled high gate
   logic ls_prev;  // last sampled low gate
   // sticky flag: a real bridge would short the supply here
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         shoot_o  <= 1'b0;
         off_cnt  <= 0;
         hs_prev  <= 1'b0;
         ls_prev  <= 1'b0;
         gap_hs_o <= 0;
         gap_ls_o <= 0;
      end
      else
      begin
         shoot_o  <= shoot_o | (|(hs_i & ls_i));
         off_cnt  <= (hs_i[0] | ls_i[0]) ? 0 : off_cnt + 1;
         hs_prev  <= hs_i[0];
         ls_prev  <= ls_i[0];
         // gap seen by a gate as it turns on
         if (hs_i[0] && !hs_prev)
            gap_hs_o <= off_cnt;
         if (ls_i[0] && !ls_prev)
            gap_ls_o <= off_cnt;
      end
   end
endmodule  // gate_driver_model

// [pwm_deadtime.sv]
// ---------------------------------------------------------------------
// break-before-make stage for one half bridge
// ---------------------------------------------------------------------
module pwm_deadtime
   import pwm_unit_pkg::*;
#(
   parameter int DW = pwm_unit_pkg::DTC_W   // delay counter width
)(
   input  wire logic          ref_clk_i,
   input  wire logic          arst_n_i,
   input  wire logic          hs_req_i,
   input  wire logic          ls_req_i,
   input  wire logic [DW-1:0] hs_delay_i,
   input  wire logic [DW-1:0] ls_delay_i,
   output logic               hs_o,
   output logic               ls_o
);

   logic [DW-1:0] hs_cnt_reg;   // cycles since high side may start
   logic [DW-1:0] ls_cnt_reg;   // cycles since low side may start
   logic          hs_reg;       // gated high side
   logic          ls_reg;       // gated low side
   logic          hs_next;
   logic          ls_next;

   // a side may close only when the other is open and was not asked
   assign hs_next = hs_req_i & ~ls_req_i & ~ls_reg
                    & (hs_cnt_reg >= hs_delay_i);
   assign ls_next = ls_req_i & ~hs_req_i & ~hs_reg
                    & (ls_cnt_reg >= ls_delay_i);

   // ----------------------------------------------------------------
   // delay counters restart while the opposite side conducts
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hs_cnt_reg <= '0;
         ls_cnt_reg <= '0;
      end
      else
      begin
         // saturate so a lowered delay still releases
         if (!hs_req_i || ls_reg)
            hs_cnt_reg <= '0;
         else if (hs_cnt_reg < hs_delay_i)
            hs_cnt_reg <= hs_cnt_reg + DW'(1);
         if (!ls_req_i || hs_reg)
            ls_cnt_reg <= '0;
         else if (ls_cnt_reg < ls_delay_i)
            ls_cnt_reg <= ls_cnt_reg + DW'(1);
      end
   end

   // outputs from flops so no glitch reaches the gate driver
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hs_reg <= 1'b0;
         ls_reg <= 1'b0;
      end
      else
      begin
         hs_reg <= hs_next;
         ls_reg <= ls_next;
      end
   end

   assign hs_o = hs_reg;
   assign ls_o = ls_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_ls_bbm;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(ls_reg) |-> !$past(hs_reg)
                        && $past(ls_cnt_reg) >= $past(ls_delay_i);
   endproperty
   a_ls_bbm: assert property (p_ls_bbm)
      else $error("low side closed before dead time elapsed");

   property p_hs_bbm;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(hs_reg) |-> !$past(ls_reg)
                        && $past(hs_cnt_reg) >= $past(hs_delay_i);
   endproperty
   a_hs_bbm: assert property (p_hs_bbm)
      else $error("high side closed before dead time elapsed");

endmodule // pwm_deadtime

// [pwm_unit_pkg.sv]
package pwm_unit_pkg;

   // ----------------------------------------------------------------
   // register indices, one per documented register
   // ----------------------------------------------------------------
   localparam int          IDX_W         = 6;
   localparam logic [5:0]  IDX_CFG       = 6'h24;  // configuration word
   localparam logic [5:0]  IDX_DUTY0     = 6'h25;  // first on-time reg
   localparam logic [5:0]  IDX_SHIFT0    = 6'h29;  // first shift reg
   localparam logic [5:0]  IDX_PULSE_AB  = 6'h2d;  // trigger positions
   localparam logic [5:0]  IDX_PULSE_LEN = 6'h2e;  // trigger length

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CFG_W  = 64;  // configuration word width
   localparam int CNT_W  = 12;  // counter, on-time, shift width
   localparam int CHOP_W = 3;   // chopper mode field width
   localparam int ALN_W  = 2;   // alignment field width
   localparam int DT_W   = 8;   // dead-time field width
   localparam int DTC_W  = 9;   // dead time in own clock cycles
   localparam int PLEN_W = 8;   // trigger pulse length width
   localparam int NTRIG  = 5;   // trigger outputs

   // ----------------------------------------------------------------
   // field positions in the configuration word
   // ----------------------------------------------------------------
   localparam int CFG_MAX_LSB   = 0;
   localparam int CFG_CHOP_LSB  = 16;
   localparam int CFG_CHOP_STEP = 4;
   localparam int CFG_ALN_LSB   = 32;
   localparam int CFG_POL_LS    = 40;
   localparam int CFG_POL_HS    = 41;
   localparam int CFG_POL_TRIG  = 42;  // ab, b, center, a, zero upward
   localparam int CFG_BBM_LS    = 48;
   localparam int CFG_BBM_HS    = 56;
   localparam int POS_A_LSB     = 0;
   localparam int POS_B_LSB     = 16;

   // trigger bit order inside the trigger vector
   localparam int TRIG_AB     = 0;
   localparam int TRIG_B      = 1;
   localparam int TRIG_CENTER = 2;
   localparam int TRIG_A      = 3;
   localparam int TRIG_ZERO   = 4;

   // ----------------------------------------------------------------
   // timing: dead-time unit against our own clock period
   // ----------------------------------------------------------------
   localparam int DT_UNIT_NS    = 10;  // 100 MHz dead-time unit
   localparam int CLK_PERIOD_NS = 8;   // 125 MHz block clock

   // reset values
   localparam logic [CFG_W-1:0] CFG_RST = 64'h0;
   localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

   // ----------------------------------------------------------------
   // modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CHOP_OFF      = 3'b000,  // both switches open
      CHOP_COMPL    = 3'b001,  // complementary high and low side
      CHOP_HS_ONLY  = 3'b010,  // high side chops, low side open
      CHOP_LS_ONLY  = 3'b011,  // low side chops, high side open
      CHOP_LS_BRAKE = 3'b100   // low side held on
   } chop_mode_e;

   typedef enum logic [1:0] {
      ALIGN_LEFT   = 2'b00,
      ALIGN_RIGHT  = 2'b01,
      ALIGN_CENTER = 2'b10,
      ALIGN_CTR2   = 2'b11
   } align_e;

endpackage
